// *** shared/mfpc_regs.vh ***
// Purpose: register offsets, field positions and timing for the pin 7..9 configuration block
// Assumes: 8-bit registers on the device's internal register port, 100 MHz clock
// Notes: definitions only
`ifndef MFPC_REGS_VH
`define MFPC_REGS_VH

// register offsets
`define MFPC_OFS_PIN7_CONFIG 8'h37
`define MFPC_OFS_PIN8_CONFIG 8'h38
`define MFPC_OFS_PIN9_CONFIG 8'h39
`define MFPC_OFS_OUT_LEVEL_1 8'h3D

// field positions in each pin register
`define MFPC_SEL_HI 7
`define MFPC_SEL_LO 5
`define MFPC_BIT_FILTER 4
`define MFPC_BIT_PULL_EN 3
`define MFPC_BIT_PULL_DIR 2
`define MFPC_BIT_OPEN_DRAIN 1
`define MFPC_BIT_DIRECTION 0

// level bits of pins 7 and 8 in the output-level register
`define MFPC_BIT_OUT7 6
`define MFPC_BIT_OUT8 7

// function codes
`define MFPC_FN_PLAIN 3'h0
`define MFPC_FN_ALT1 3'h1
`define MFPC_FN_ALT2 3'h2
`define MFPC_FN_ALT3 3'h3
`define MFPC_FN_SLEEP1 3'h4
`define MFPC_FN_SLEEP2 3'h5
`define MFPC_FN_WAKE1 3'h6
`define MFPC_FN_WAKE2 3'h7

// reset image used when no non-volatile default is supplied
`define MFPC_RESET_CONFIG 8'h0A

// deglitch time and clock rate
`define MFPC_FILTER_NS 8000
`define MFPC_CLK_PERIOD_NS 10
`define MFPC_FILTER_CYCLES (`MFPC_FILTER_NS / `MFPC_CLK_PERIOD_NS)
// filter counter width, wide enough for the default filter count
`define MFPC_FILTER_CW 10

`endif

// *** hdl/mfpc_pin_filter.v ***
// Purpose: two-flop synchroniser plus optional deglitch filter for one pin input
// Assumes: pin_in is asynchronous to clk
// Notes: with filtering on, the output follows only after a stable run of FILTER_CYCLES
`timescale 1ns/10ps
`include "mfpc_regs.vh"
module mfpc_pin_filter #(
    parameter FILTER_CYCLES = `MFPC_FILTER_CYCLES,
    parameter CW = 10
) (
    input wire clk,
    input wire arst_n,
    input wire pin_in,
    input wire filter_en,
    output reg level_r
);
    reg sync1_r; // first stage, read only by sync2_r
    reg sync2_r; // synchronised level
    reg [CW-1:0] cnt_r; // cycles the synchronised level has stood unchanged
    localparam integer LIMIT_FULL = FILTER_CYCLES - 1; // last count before accept
    wire [CW-1:0] limit = LIMIT_FULL[CW-1:0]; // cut to the counter width on purpose

    // synchroniser
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
        end
    end

    // filter: restart count whenever the input equals the output, accept after full stable time
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= {CW{1'b0}};
            level_r <= 1'b0;
        end else if (!filter_en) begin
            // only synchronisation
            cnt_r <= {CW{1'b0}};
            level_r <= sync2_r; // (R4)
        end else if (sync2_r == level_r) begin
            // no change pending
            cnt_r <= {CW{1'b0}};
        end else if (cnt_r == limit) begin
            // stable for the whole filter time
            cnt_r <= {CW{1'b0}};
            level_r <= sync2_r; // (R13)
        end else begin
            cnt_r <= cnt_r + 1'b1; // (R4)
        end
    end
endmodule

// *** hdl/mfpc_pin_config.v ***
// Purpose: configuration registers and function routing for multi-function pins 7, 8 and 9
// Assumes: register port is the device's internal 8-bit one; pad cells take pull controls
// Notes: reset images are loaded from non-volatile defaults when nvm_valid goes high
//
// How it works
// (R1) pin 7 select: plain, error, reference, monitor1, sleep, wake
// (R2) pin 8 select: plain, link clock, monitor2, sleep, wake
// (R3) pin 9 select: plain, link data, power_good_output, sync, sleep, wake
// (R4) filter bit adds 8 us deglitch to inputs
// (R5) bit 3 enables the pull resistor
// (R6) bit 2 picks pull up, only when enabled
// (R7) bit 1 picks open-drain or push-pull output
// (R8) bit 0 sets direction, 1 is output
// (R9) each register resets to 0x0A; the 0x3D level bits reset to 0, so 0x3D reads 0x00
// (R10) reset values come from non-volatile defaults
// (R11) three read/write registers at 0x37..0x39
// (R12) plain output level from 0x3D bits
// (R13) filtered level changes only after full stable time
`timescale 1ns/10ps
`include "mfpc_regs.vh"
module mfpc_pin_config #(
    parameter FILTER_CYCLES = `MFPC_FILTER_CYCLES
) (
    input wire clk,
    input wire arst_n,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata_r,
    input wire nvm_valid,
    input wire [7:0] nvm_pin7_config,
    input wire [7:0] nvm_pin8_config,
    input wire [7:0] nvm_pin9_config,
    input wire [1:0] nvm_out_level,
    input wire [2:0] pin_in,
    output reg [2:0] pin_out_r,
    output reg [2:0] pin_oe_r,
    output reg [2:0] pin_pull_up_en_r,
    output reg [2:0] pin_pull_down_en_r,
    input wire reference_output,
    input wire power_good_output,
    input wire pmic_link_data_out,
    input wire pmic_link_data_oe,
    output reg processor_error_input_r,
    output reg voltage_monitor_one_input_r,
    output reg voltage_monitor_two_input_r,
    output reg pmic_link_clock_pin_r,
    output reg pmic_link_data_pin_r,
    output reg external_sync_clock_input_r,
    output reg [2:0] sleep_control_one_r,
    output reg [2:0] sleep_control_two_r,
    output reg [2:0] wake_one_r,
    output reg [2:0] wake_two_r,
    output reg [2:0] plain_input_r
);
    reg [7:0] cfg_r [0:2]; // pin configuration registers, index 0 is pin 7
    reg [1:0] out_level_r; // plain output levels, bit 0 pin 7, bit 1 pin 8
    reg nvm_seen_r; // non-volatile defaults already taken
    wire [2:0] level; // filtered input levels
    reg [2:0] drv_out_nxt; // driven value per pin
    reg [2:0] drv_oe_nxt; // driver enable per pin
    reg [2:0] src_val; // value the selected function wants on the pin
    reg [2:0] src_oe; // selected function drives the pin
    reg [7:0] rdata_nxt; // read data mux
    reg [2:0] sel; // loop copy of select

    // one filter per pin
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_filt
            mfpc_pin_filter #(
                .FILTER_CYCLES(FILTER_CYCLES),
                .CW(`MFPC_FILTER_CW)
            ) u_filt (
                .clk(clk),
                .arst_n(arst_n),
                .pin_in(pin_in[g]),
                .filter_en(cfg_r[g][`MFPC_BIT_FILTER]),
                .level_r(level[g])
            );
        end
    endgenerate

    // register file: fixed reset image, non-volatile load once, then software writes
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_r[0] <= `MFPC_RESET_CONFIG; // (R9)
            cfg_r[1] <= `MFPC_RESET_CONFIG; // (R9)
            cfg_r[2] <= `MFPC_RESET_CONFIG; // (R9)
            out_level_r <= 2'h0;
            nvm_seen_r <= 1'b0;
        end else if (nvm_valid && !nvm_seen_r) begin
            // load defaults from non-volatile memory
            cfg_r[0] <= nvm_pin7_config; // (R10)
            cfg_r[1] <= nvm_pin8_config; // (R10)
            cfg_r[2] <= nvm_pin9_config; // (R10)
            out_level_r <= nvm_out_level; // (R10)
            nvm_seen_r <= 1'b1;
        end else if (reg_wr) begin
            // software writes, all fields read/write
            case (reg_addr)
                `MFPC_OFS_PIN7_CONFIG: begin
                    cfg_r[0] <= reg_wdata; // (R11)
                end
                `MFPC_OFS_PIN8_CONFIG: begin
                    cfg_r[1] <= reg_wdata; // (R11)
                end
                `MFPC_OFS_PIN9_CONFIG: begin
                    cfg_r[2] <= reg_wdata; // (R11)
                end
                `MFPC_OFS_OUT_LEVEL_1: begin
                    out_level_r[0] <= reg_wdata[`MFPC_BIT_OUT7]; // (R12)
                    out_level_r[1] <= reg_wdata[`MFPC_BIT_OUT8]; // (R12)
                end
                default: begin
                    out_level_r <= out_level_r; // unmapped: ignored
                end
            endcase
        end
    end

    // read mux; unmapped offsets read zero
    always @* begin
        rdata_nxt = 8'h00;
        case (reg_addr)
            `MFPC_OFS_PIN7_CONFIG: rdata_nxt = cfg_r[0]; // (R11)
            `MFPC_OFS_PIN8_CONFIG: rdata_nxt = cfg_r[1]; // (R11)
            `MFPC_OFS_PIN9_CONFIG: rdata_nxt = cfg_r[2]; // (R11)
            `MFPC_OFS_OUT_LEVEL_1: begin
                rdata_nxt[`MFPC_BIT_OUT7] = out_level_r[0];
                rdata_nxt[`MFPC_BIT_OUT8] = out_level_r[1];
            end
            default: rdata_nxt = 8'h00;
        endcase
    end

    // output side function select per pin
    always @* begin : src_select
        integer i; // loop index, local so each process owns its own
        i = 0;
        src_val = 3'h0;
        src_oe = 3'h0;
        sel = 3'h0;
        for (i = 0; i < 3; i = i + 1) begin
            sel = cfg_r[i][`MFPC_SEL_HI:`MFPC_SEL_LO];
            if (sel == `MFPC_FN_PLAIN && i < 2) begin
                src_val[i] = out_level_r[i]; // (R12)
                src_oe[i] = 1'b1;
            end else if (sel == `MFPC_FN_PLAIN) begin
                src_val[i] = 1'b0; // pin 9 level bit lives elsewhere
                src_oe[i] = 1'b1;
            end
        end
        // pin 7 reference output
        if (cfg_r[0][`MFPC_SEL_HI:`MFPC_SEL_LO] == `MFPC_FN_ALT2) begin
            src_val[0] = reference_output; // (R1)
            src_oe[0] = 1'b1;
        end
        // pin 9 power good or link data
        if (cfg_r[2][`MFPC_SEL_HI:`MFPC_SEL_LO] == `MFPC_FN_ALT2) begin
            src_val[2] = power_good_output; // (R3)
            src_oe[2] = 1'b1;
        end else if (cfg_r[2][`MFPC_SEL_HI:`MFPC_SEL_LO] == `MFPC_FN_ALT1) begin
            src_val[2] = pmic_link_data_out; // (R3)
            src_oe[2] = pmic_link_data_oe;
        end
    end

    // pad driver: direction, then push-pull or open-drain
    always @* begin : pad_drive
        integer i; // loop index, local so each process owns its own
        i = 0;
        drv_out_nxt = 3'h0;
        drv_oe_nxt = 3'h0;
        for (i = 0; i < 3; i = i + 1) begin
            if (cfg_r[i][`MFPC_BIT_DIRECTION] && src_oe[i]) begin // (R8)
                if (cfg_r[i][`MFPC_BIT_OPEN_DRAIN]) begin
                    drv_out_nxt[i] = 1'b0; // (R7)
                    drv_oe_nxt[i] = ~src_val[i]; // (R7)
                end else begin
                    drv_out_nxt[i] = src_val[i]; // (R7)
                    drv_oe_nxt[i] = 1'b1;
                end
            end
        end
    end

    // registered pad controls and read data
    always @(posedge clk or negedge arst_n) begin : pad_regs
        integer i; // loop index, local so each process owns its own
        if (!arst_n) begin
            pin_out_r <= 3'h0;
            pin_oe_r <= 3'h0;
            pin_pull_up_en_r <= 3'h0;
            pin_pull_down_en_r <= 3'h0;
            reg_rdata_r <= 8'h00;
        end else begin
            pin_out_r <= drv_out_nxt;
            pin_oe_r <= drv_oe_nxt;
            for (i = 0; i < 3; i = i + 1) begin
                pin_pull_up_en_r[i] <= cfg_r[i][`MFPC_BIT_PULL_EN] &
                    cfg_r[i][`MFPC_BIT_PULL_DIR]; // (R5) (R6)
                pin_pull_down_en_r[i] <= cfg_r[i][`MFPC_BIT_PULL_EN] &
                    ~cfg_r[i][`MFPC_BIT_PULL_DIR]; // (R5) (R6)
            end
            if (reg_rd) begin
                reg_rdata_r <= rdata_nxt;
            end
        end
    end

    // input side routing of filtered levels to functions
    always @(posedge clk or negedge arst_n) begin : in_route
        integer i; // loop index, local so each process owns its own
        if (!arst_n) begin
            processor_error_input_r <= 1'b0;
            voltage_monitor_one_input_r <= 1'b0;
            voltage_monitor_two_input_r <= 1'b0;
            pmic_link_clock_pin_r <= 1'b0;
            pmic_link_data_pin_r <= 1'b0;
            external_sync_clock_input_r <= 1'b0;
            sleep_control_one_r <= 3'h0;
            sleep_control_two_r <= 3'h0;
            wake_one_r <= 3'h0;
            wake_two_r <= 3'h0;
            plain_input_r <= 3'h0;
        end else begin
            processor_error_input_r <= level[0] &
                (cfg_r[0][`MFPC_SEL_HI:`MFPC_SEL_LO] == `MFPC_FN_ALT1); // (R1)
            voltage_monitor_one_input_r <= level[0] &
                (cfg_r[0][`MFPC_SEL_HI:`MFPC_SEL_LO] == `MFPC_FN_ALT3); // (R1)
            pmic_link_clock_pin_r <= level[1] &
                (cfg_r[1][`MFPC_SEL_HI:`MFPC_SEL_LO] == `MFPC_FN_ALT1); // (R2)
            voltage_monitor_two_input_r <= level[1] &
                ((cfg_r[1][`MFPC_SEL_HI:`MFPC_SEL_LO] == `MFPC_FN_ALT2) |
                 (cfg_r[1][`MFPC_SEL_HI:`MFPC_SEL_LO] == `MFPC_FN_ALT3)); // (R2)
            pmic_link_data_pin_r <= level[2] &
                (cfg_r[2][`MFPC_SEL_HI:`MFPC_SEL_LO] == `MFPC_FN_ALT1); // (R3)
            external_sync_clock_input_r <= level[2] &
                (cfg_r[2][`MFPC_SEL_HI:`MFPC_SEL_LO] == `MFPC_FN_ALT3); // (R3)
            for (i = 0; i < 3; i = i + 1) begin
                sleep_control_one_r[i] <= level[i] &
                    (cfg_r[i][`MFPC_SEL_HI:`MFPC_SEL_LO] == `MFPC_FN_SLEEP1); // (R2)
                sleep_control_two_r[i] <= level[i] &
                    (cfg_r[i][`MFPC_SEL_HI:`MFPC_SEL_LO] == `MFPC_FN_SLEEP2);
                wake_one_r[i] <= level[i] &
                    (cfg_r[i][`MFPC_SEL_HI:`MFPC_SEL_LO] == `MFPC_FN_WAKE1);
                wake_two_r[i] <= level[i] &
                    (cfg_r[i][`MFPC_SEL_HI:`MFPC_SEL_LO] == `MFPC_FN_WAKE2);
                plain_input_r[i] <= level[i] & ~cfg_r[i][`MFPC_BIT_DIRECTION] &
                    (cfg_r[i][`MFPC_SEL_HI:`MFPC_SEL_LO] == `MFPC_FN_PLAIN);
            end
        end
    end
endmodule

// *** testbench/mfpc_pin_config_asserts.sv ***
// Purpose: port checks on the pin 7..9 configuration block
// Assumes: pin 7 shadow follows the nvm load and register writes
// Notes: bound at the foot of this file
`timescale 1ns/10ps
module mfpc_pin_config_asserts #(
    parameter FILTER_CYCLES = 8
) (
    input wire clk,
    input wire arst_n,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata_r,
    input wire nvm_valid,
    input wire [7:0] nvm_pin7_config,
    input wire [2:0] pin_in,
    input wire [2:0] pin_out_r,
    input wire [2:0] pin_oe_r,
    input wire [2:0] pin_pull_up_en_r,
    input wire [2:0] pin_pull_down_en_r,
    input wire processor_error_input_r,
    input wire voltage_monitor_one_input_r,
    input wire [2:0] plain_input_r
);
    reg [7:0] c7_r; // shadow of the pin 7 register
    reg [1:0] up_r; // edges since reset, saturating
    reg [9:0] hi_r; // run of high samples on pin 7, saturating
    reg nv_r; // non-volatile defaults already taken
    // shadow loads defaults once after reset, then follows writes
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            c7_r <= 8'h0A;
            up_r <= 2'h0;
            hi_r <= 10'h000;
            nv_r <= 1'b0;
        end else begin
            up_r <= (up_r == 2'h3) ? up_r : up_r + 2'h1;
            hi_r <= !pin_in[0] ? 10'h000 : (hi_r == 10'h3FF) ? hi_r : hi_r + 10'h001;
            if (nvm_valid && !nv_r) begin
                c7_r <= nvm_pin7_config;
                nv_r <= 1'b1;
            end else if (reg_wr && reg_addr == 8'h37) begin
                c7_r <= reg_wdata;
            end
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // configuration unchanged long enough for the pad stage to follow
    sequence settled;
        up_r == 2'h3 && $stable(c7_r) ##1 $stable(c7_r);
    endsequence
    a_pull_up_map: assert property (
        settled |-> pin_pull_up_en_r[0] == (c7_r[3] & c7_r[2]))
        else $error("pull up control wrong");
    a_pull_down_map: assert property (
        settled |-> pin_pull_down_en_r[0] == (c7_r[3] & !c7_r[2]))
        else $error("pull down control wrong");
    a_pull_exclusive: assert property ((pin_pull_up_en_r & pin_pull_down_en_r) == 3'h0)
        else $error("both pulls on");
    a_input_no_drive: assert property (settled ##0 !c7_r[0] |-> !pin_oe_r[0])
        else $error("input pin driven");
    a_od_no_high: assert property (settled ##0 c7_r[1] |-> !pin_out_r[0])
        else $error("open drain drives high");
    a_err_gated: assert property (
        settled ##0 c7_r[7:5] != 3'h1 |-> !processor_error_input_r)
        else $error("error input not gated");
    a_mon1_gated: assert property (
        settled ##0 c7_r[7:5] != 3'h3 |-> !voltage_monitor_one_input_r)
        else $error("monitor input not gated");
    a_read_pin7: assert property (
        up_r == 2'h3 && reg_rd && reg_addr == 8'h37 |=> reg_rdata_r == $past(c7_r))
        else $error("pin 7 readback wrong");
    a_unmapped_zero: assert property (
        reg_rd && !(reg_addr inside {8'h37, 8'h38, 8'h39, 8'h3D}) |=> reg_rdata_r == 8'h00)
        else $error("unmapped read not zero");
    // a filtered rise needs a full run of high pin samples, three edges before it shows
    a_filter_hold: assert property (settled ##0 c7_r[4] && !c7_r[0] |->
        !$rose(plain_input_r[0]) || $past(hi_r, 3) >= FILTER_CYCLES)
        else $error("filtered level rose early");
endmodule
bind mfpc_pin_config mfpc_pin_config_asserts #(.FILTER_CYCLES(FILTER_CYCLES))
    mfpc_pin_config_asserts_inst (
    .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .nvm_valid(nvm_valid),
    .nvm_pin7_config(nvm_pin7_config), .pin_in(pin_in), .pin_out_r(pin_out_r),
    .pin_oe_r(pin_oe_r), .pin_pull_up_en_r(pin_pull_up_en_r),
    .pin_pull_down_en_r(pin_pull_down_en_r), .processor_error_input_r(processor_error_input_r),
    .voltage_monitor_one_input_r(voltage_monitor_one_input_r), .plain_input_r(plain_input_r));

// *** testbench/mfpc_board_model.sv ***
// Purpose: board side of pins 7..9, resolves each pad wire
// Assumes: board drives a level or leaves the pin open
// Notes: an open unpulled pin shows the inverse of the board value
`timescale 1ns/10ps
module mfpc_board_model (
    input wire [2:0] pin_out,
    input wire [2:0] pin_oe,
    input wire [2:0] pull_up,
    input wire [2:0] pull_down,
    input wire [2:0] board_val,
    input wire [2:0] board_en,
    output wire [2:0] pin_level
);
    // device drive wins, then board drive, then the pull, else the inverse of board_val
    assign pin_level = (pin_oe & pin_out) | (~pin_oe & board_en & board_val)
        | (~pin_oe & ~board_en & (pull_up | (~pull_down & ~board_val)));
endmodule

// *** testbench/mfpc_pin_config_tb_top.sv ***
// Purpose: self-checking bench for the pin 7..9 configuration block
// Assumes: filter shortened to 8 cycles, defaults become valid after the reset image is read
// Notes: board model feeds the resolved pads back to pin_in
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); end end
module mfpc_pin_config_tb_top;
    reg clk = 0;
    reg arst_n = 0;
    reg [7:0] reg_addr = 8'h00;
    reg [7:0] reg_wdata = 8'h00;
    reg reg_wr = 0, reg_rd = 0, ref_src = 0, pg_src = 0, lnk_out = 0, lnk_oe = 0;
    reg [2:0] board_val = 3'h7, board_en = 3'h7;
    reg nvm_ok = 0; // non-volatile defaults valid
    reg [5:0] fn_exp; // expected single-pin function inputs
    reg [4:0] pin_exp; // expected per-pin function inputs
    wire [7:0] rdata;
    wire [2:0] lvl, pout, poe, pup, pdn, slp1, slp2, wk1, wk2, plain;
    wire err, mon1, mon2, lclk, ldat, sync;
    int num_errors = 0;
    int cmp_count = 0;
    int p, c;
    reg seen;
    always #5 clk = ~clk;
    mfpc_pin_config #(.FILTER_CYCLES(8)) mfpc_pin_config_inst (.clk(clk), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_r(rdata), .nvm_valid(nvm_ok), .nvm_pin7_config(8'h0A),
        .nvm_pin8_config(8'h5C), .nvm_pin9_config(8'h0A), .nvm_out_level(2'h2),
        .pin_in(lvl), .pin_out_r(pout), .pin_oe_r(poe), .pin_pull_up_en_r(pup),
        .pin_pull_down_en_r(pdn), .reference_output(ref_src), .power_good_output(pg_src),
        .pmic_link_data_out(lnk_out), .pmic_link_data_oe(lnk_oe),
        .processor_error_input_r(err), .voltage_monitor_one_input_r(mon1),
        .voltage_monitor_two_input_r(mon2), .pmic_link_clock_pin_r(lclk),
        .pmic_link_data_pin_r(ldat), .external_sync_clock_input_r(sync),
        .sleep_control_one_r(slp1), .sleep_control_two_r(slp2), .wake_one_r(wk1),
        .wake_two_r(wk2), .plain_input_r(plain));
    mfpc_board_model mfpc_board_model_inst (.pin_out(pout), .pin_oe(poe), .pull_up(pup),
        .pull_down(pdn), .board_val(board_val), .board_en(board_en), .pin_level(lvl));
    // one register write, strobe held for a single edge
    task wr(input [7:0] a, input [7:0] d); begin
        @(negedge clk); reg_addr = a; reg_wdata = d; reg_wr = 1'b1;
        @(negedge clk); reg_wr = 1'b0;
    end endtask
    // one register read, data judged after the capture edge
    task rd(input [7:0] a, input [7:0] e); begin
        @(negedge clk); reg_addr = a; reg_rd = 1'b1;
        @(negedge clk); reg_rd = 1'b0;
        `CHK(rdata, e)
    end endtask
    // write a pin register and let the pad and input stages follow
    task cfg(input [1:0] n, input [7:0] d); begin
        wr(8'h37 + {6'h00, n}, d);
        repeat (6) @(negedge clk);
    end endtask
    task t_reset; begin
        `CHK(pdn, 3'h7)
        rd(8'h37, 8'h0A);
        rd(8'h38, 8'h0A);
        rd(8'h39, 8'h0A);
        nvm_ok = 1'b1;
        rd(8'h38, 8'h5C);
        rd(8'h3D, 8'h80);
        `CHK({pup[2:1], pdn[2:1]}, 4'h6)
        wr(8'h3A, 8'hFF);
        rd(8'h3A, 8'h00);
    end endtask
    task t_rw; begin
        for (p = 0; p < 3; p++) begin
            wr(8'h37 + p[7:0], 8'hA5);
            wr(8'h37 + p[7:0], 8'h5A);
            rd(8'h37 + p[7:0], 8'h5A);
        end
        wr(8'h3D, 8'hFF);
        rd(8'h3D, 8'hC0);
    end endtask
    // pull controls, with the board letting pin 7 float
    task t_pull; begin
        board_en[0] = 1'b0;
        for (c = 0; c < 4; c++) begin
            cfg(0, {4'h0, ~c[1], ~c[0], 2'h0});
            `CHK(pup[0], (~c[1] & ~c[0]) & 1'b1)
            `CHK(pdn[0], (~c[1] & c[0]) & 1'b1)
            `CHK(plain[0], (~c[1] & ~c[0]) & 1'b1)
        end
    end endtask
    task t_drive; begin
        wr(8'h3D, 8'h40);
        cfg(0, 8'h01);
        `CHK({poe[0], pout[0]}, 2'h3)
        cfg(0, 8'h03);
        `CHK(poe[0], 1'b0)
        wr(8'h3D, 8'h80);
        repeat (3) @(negedge clk);
        `CHK({poe[0], pout[0]}, 2'h2)
        cfg(1, 8'h01);
        `CHK({poe[1], pout[1]}, 2'h3)
        ref_src = 1'b1;
        pg_src = 1'b1;
        cfg(0, 8'h41);
        `CHK({poe[0], pout[0]}, 2'h3)
        ref_src = 1'b0;
        repeat (2) @(negedge clk);
        `CHK({poe[0], pout[0]}, 2'h2)
        cfg(2, 8'h01);
        `CHK({poe[2], pout[2]}, 2'h2)
        lnk_oe = 1'b1;
        cfg(2, 8'h21);
        `CHK({poe[2], pout[2]}, 2'h2)
        lnk_out = 1'b1;
        repeat (2) @(negedge clk);
        `CHK({poe[2], pout[2]}, 2'h3)
        lnk_oe = 1'b0;
        repeat (2) @(negedge clk);
        `CHK(poe[2], 1'b0)
        cfg(2, 8'h41);
        `CHK({poe[2], pout[2]}, 2'h3)
    end endtask
    task t_func; begin
        board_en = 3'h7;
        board_val = 3'h7;
        for (p = 0; p < 3; p++) begin
            for (c = 0; c < 8; c++) begin
                cfg(p[1:0], {c[2:0], 5'h00});
                fn_exp = {p == 0 && c == 1, p == 0 && c == 3, p == 1 && c == 1,
                    p == 1 && (c == 2 || c == 3), p == 2 && c == 1, p == 2 && c == 3};
                pin_exp = {c == 4, c == 5, c == 6, c == 7, c == 0};
                `CHK({err, mon1, lclk, mon2, ldat, sync}, fn_exp)
                `CHK({slp1[p], slp2[p], wk1[p], wk2[p], plain[p]}, pin_exp)
            end
        end
    end endtask
    task t_filter; begin
        board_val[0] = 1'b0;
        cfg(0, 8'h10);
        board_val[0] = 1'b1;
        repeat (5) @(negedge clk);
        board_val[0] = 1'b0;
        repeat (12) @(negedge clk);
        `CHK(plain[0], 1'b0)
        board_val[0] = 1'b1;
        repeat (6) @(negedge clk);
        `CHK(plain[0], 1'b0)
        repeat (10) @(negedge clk);
        `CHK(plain[0], 1'b1)
        board_val[0] = 1'b0;
        cfg(0, 8'h00);
        seen = 1'b0;
        board_val[0] = 1'b1;
        repeat (2) @(negedge clk);
        board_val[0] = 1'b0;
        repeat (6) begin @(negedge clk); seen = seen | (plain[0] === 1'b1); end
        `CHK(seen, 1'b1)
    end endtask
    task conclude; begin
        if (num_errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    end endtask
    initial begin
        #100000;
        num_errors++;
        conclude;
    end
    initial begin
        repeat (5) @(negedge clk);
        arst_n = 1'b1;
        @(negedge clk);
        t_reset;
        t_rw;
        t_pull;
        t_drive;
        t_func;
        t_filter;
        conclude;
    end
endmodule
